// ---- dv/bus_partner_model.sv ----
// Far-side memory and I/O model with a slow asynchronous ready
module bus_partner_model (
  input wire logic mclk,
  input wire logic ale,
  input wire logic [15:0] muxedAddrData,
  input wire logic [2:0] busCycleStatus,
  input wire logic readStrobeN,
  input wire logic readStrobeOe,
  input wire logic writeStrobeN,
  input wire logic writeStrobeOe,
  input wire logic [7:0] readyLag,
  output logic asyncReadyIn,
  output logic [15:0] muxedAddrDataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [32];
  logic [15:0] lastQ = 16'h0000;
  logic [4:0] idxQ = 5'h00;
  logic [7:0] waitQ = 8'h00;
  logic rdLine;
  logic wrLine;
  // Strobe lines as seen on the board; data toggles when released
  assign rdLine = readStrobeOe ? readStrobeN : 1'b1; // Pull-up
  assign wrLine = writeStrobeOe ? writeStrobeN : 1'b1;
  assign muxedAddrDataIn = rdLine ? ~lastQ : mem[idxQ];
  assign asyncReadyIn = !(rdLine && wrLine) && waitQ >= readyLag;
  // Address latch with space from status bit two, write capture, ready delay
  always @(posedge mclk) begin
    lastQ <= muxedAddrDataIn;
    if (ale) begin
      idxQ <= {busCycleStatus[2], muxedAddrData[4:1]};
    end
    if (!wrLine) begin
      mem[idxQ] <= muxedAddrData;
    end
    waitQ <= (rdLine && wrLine) ? 8'h00 : waitQ + {7'h00, waitQ != 8'hfe};
  end
endmodule : bus_partner_model

// ---- dv/local_bus_clock_reset_ctrl_chk.sv ----
// Port checker for the local bus front end, bound to the top module
module local_bus_clock_reset_ctrl_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic powerOnClearInputN,
  input wire logic busRequestIn,
  input wire logic systemClockOutput,
  input wire logic resetOut,
  input wire logic ale,
  input wire logic busGrantOut,
  input wire logic muxedAddrDataOe,
  input wire logic busCycleStatusOe,
  input wire logic [2:0] busCycleStatus,
  input wire logic lockN,
  input wire logic lockOe,
  input wire logic readStrobeN,
  input wire logic readStrobeOe,
  input wire logic writeStrobeN,
  input wire logic writeStrobeOe,
  input wire logic transceiverEnableN,
  input wire logic transceiverEnableOe,
  input wire logic transceiverDirection
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Relations between the block's ports
  // ----------------------------------------------------------------
  clk_toggle_a: assert property ($past(arst_n) |-> systemClockOutput != $past(systemClockOutput))
    else $error("clock output missed a toggle");
  grant_float_a: assert property (busGrantOut |-> !muxedAddrDataOe && !readStrobeOe && !writeStrobeOe && !busCycleStatusOe && !transceiverEnableOe && !lockOe)
    else $error("bus driven while granted");
  reset_quiet_a: assert property (resetOut |-> !ale && !busGrantOut && !muxedAddrDataOe)
    else $error("latch, grant or data active in reset");
  reset_level_a: assert property (resetOut && readStrobeOe |-> readStrobeN && writeStrobeN && transceiverEnableN && lockN && busCycleStatus == 3'h7)
    else $error("reset drive level wrong");
  reset_release_a: assert property ($rose(resetOut) |-> ##[0:2] (readStrobeOe && transceiverEnableOe) ##[1:3] (!readStrobeOe && !transceiverEnableOe && !lockOe && !busCycleStatusOe))
    else $error("reset drive not one clock");
  ale_pulse_a: assert property ($rose(ale) |=> ale ##1 !ale)
    else $error("latch strobe not one clock");
  stretch_len_a: assert property ($rose(resetOut) |=> resetOut [*8] ##1 resetOut)
    else $error("reset output too short");
  stretch_end_a: assert property ($fell(resetOut) |-> $past(powerOnClearInputN, 10))
    else $error("reset output ended early");
  grant_sync_a: assert property ($rose(busGrantOut) |-> $past(busRequestIn, 2))
    else $error("grant before synchronised request");
  grant_drop_a: assert property ($fell(busGrantOut) |-> !$past(busRequestIn, 2))
    else $error("grant dropped with request high");
  read_dir_a: assert property (readStrobeOe && !readStrobeN |-> !transceiverDirection && writeStrobeN)
    else $error("read strobe with write direction");
  den_dir_a: assert property ($changed(transceiverDirection) |-> transceiverEnableN)
    else $error("direction changed with enable low");
endmodule : local_bus_clock_reset_ctrl_chk

bind local_bus_clock_reset_ctrl local_bus_clock_reset_ctrl_chk i_chk (.*);

// ---- dv/test_local_bus_clock_reset_ctrl.sv ----
// Self-checking bench for the local bus front end
module test_local_bus_clock_reset_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic powerOnClearInputN = 1'b1;
  logic busRequestIn = 1'b0;
  logic syncReadyIn = 1'b0;
  logic cpuReq = 1'b0;
  logic cpuWrite = 1'b0;
  logic cpuIo = 1'b0;
  logic cpuLock = 1'b0;
  logic cpuUpperByte = 1'b1;
  logic ignoreReady = 1'b0;
  logic [1:0] waitStates = 2'h0;
  logic [19:0] cpuAddr = 20'h00000;
  logic [15:0] cpuWdata = 16'h0000;
  logic [7:0] readyLag = 8'hff;
  logic asyncReadyIn, systemClockOutput, resetOut, ale, busGrantOut, cpuDone, followerMode;
  logic coprocessorOpcodeTrap, muxedAddrDataOe, upperAddressOe, upperByteEnableN, lockN, lockOe;
  logic upperByteEnableOe, busCycleStatusOe, readStrobeN, readStrobeOe, writeStrobeN;
  logic writeStrobeOe, transceiverEnableN, transceiverEnableOe, transceiverDirection;
  logic transceiverDirectionOe;
  logic [15:0] muxedAddrDataIn, muxedAddrData, cpuRdata, rdQ;
  logic [3:0] upperAddress;
  logic [2:0] busCycleStatus;
  int fails = 0;
  int tests_run = 0;
  int n;

  local_bus_clock_reset_ctrl i_dut (.*);
  bus_partner_model i_mem (.*);

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait: 0 done, 1 grant, 2 reset output low
  task automatic waitFor(input int sel);
    n = 0;
    while ((sel == 0 ? cpuDone : sel == 1 ? busGrantOut : !resetOut) !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 400) begin
        fails++;
        conclude();
      end
    end
  endtask : waitFor

  // One processor bus cycle, request held until done
  task automatic cyc(input logic w, input logic i, input logic [19:0] a, input logic [15:0] d);
    cpuWrite = w;
    cpuIo = i;
    cpuAddr = a;
    cpuWdata = d;
    cpuReq = 1'b1;
    waitFor(0);
    rdQ = cpuRdata;
    cpuReq = 1'b0;
    @(posedge mclk);
    #1;
  endtask : cyc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    waitFor(2);
    // Control block cycles finish although no ready ever comes
    cyc(1'b0, 1'b1, 20'h0fffe, 16'h0000);
    chk(rdQ, lbc_pkg::RELOC_RESET);
    chk({14'h0, followerMode, coprocessorOpcodeTrap}, 16'h0000);
    cyc(1'b1, 1'b1, 20'h0fffe, 16'hffff);
    chk({14'h0, followerMode, coprocessorOpcodeTrap}, 16'h0003);
    cyc(1'b0, 1'b0, 20'hffffe, 16'h0000);
    chk(rdQ, 16'hdfff);
    cyc(1'b0, 1'b0, 20'hfff10, 16'h0000);
    chk(rdQ, 16'h0000);
    chk({10'h0, upperAddressOe, upperByteEnableN, upperAddress}, 16'h002f);
    // External writes and reads over wait counts, ready kinds and spaces
    for (int k = 0; k < 8; k++) begin
      waitStates = k[1:0];
      ignoreReady = (k == 6);
      syncReadyIn = (k == 7);
      readyLag = (k >= 6) ? 8'hff : 8'(k * 2);
      cyc(1'b1, k[2], 20'(k * 2 + 2), 16'(16'h1234 * (k + 1)));
      chk(16'(n >= 8 + 2 * k[1:0]), 16'h0001);
      cyc(1'b0, k[2], 20'(k * 2 + 2), 16'h0000);
      chk(rdQ, 16'(16'h1234 * (k + 1)));
    end
    // Bus handed away; a pending cycle waits until the request drops
    busRequestIn = 1'b1;
    waitFor(1);
    chk({12'h0, muxedAddrDataOe, readStrobeOe, writeStrobeOe, transceiverEnableOe}, 16'h0);
    chk({13'h0, upperAddressOe, upperByteEnableOe, transceiverDirectionOe}, 16'h0);
    chk({14'h0, lockOe, busCycleStatusOe}, 16'h0);
    fork
      cyc(1'b0, 1'b0, 20'h00002, 16'h0000);
      begin
        repeat (20) @(posedge mclk);
        #1;
        busRequestIn = 1'b0;
      end
    join
    chk(16'(n > 20), 16'h0001);
    chk(rdQ, 16'h1234);
    chk({15'h0, busGrantOut}, 16'h0000);
    // Reset pin low for six clocks stretches the reset output
    powerOnClearInputN = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    powerOnClearInputN = 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      #1;
      n += int'(resetOut);
    end
    chk(16'(n >= 10), 16'h0001);
    chk({15'h0, resetOut}, 16'h0000);
    chk({14'h0, followerMode, coprocessorOpcodeTrap}, 16'h0000);
    conclude();
  end
endmodule : test_local_bus_clock_reset_ctrl

// ---- logic/lbc_pkg.sv ----
// Constants, encodings and types shared by the local bus front end
package lbc_pkg;
  // ----------------------------------------------------------------
  // Clock and reset timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 25;
  localparam int OSC_DIV = 2;
  localparam int RESET_IN_MIN_CLKS = 6;
  localparam int RESET_OUT_MIN_CLKS = 5;
  localparam logic [3:0] RESET_HOLD_MCLK = 4'(RESET_OUT_MIN_CLKS * OSC_DIV);
  localparam logic [1:0] RESET_DRIVE_MCLK = 2'(OSC_DIV);

  // ----------------------------------------------------------------
  // Control block and its relocation register
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOC_OFS = 8'hfe;
  localparam logic [15:0] RELOC_RESET = 16'h00ff;
  localparam logic [15:0] RELOC_WMASK = 16'hdfff;
  localparam int RELOC_BASE_MSB = 11;
  localparam int RELOC_MEM_BIT = 12;
  localparam int RELOC_FOLLOW_BIT = 14;
  localparam int RELOC_ESC_BIT = 15;

  // ----------------------------------------------------------------
  // Bus cycle status codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STAT_IO_RD = 3'h1;
  localparam logic [2:0] STAT_IO_WR = 3'h2;
  localparam logic [2:0] STAT_MEM_RD = 3'h5;
  localparam logic [2:0] STAT_MEM_WR = 3'h6;
  localparam logic [2:0] STAT_PASSIVE = 3'h7;

  typedef enum logic [2:0] {
    BUS_RESET, BUS_IDLE, BUS_ADDR, BUS_STROBE, BUS_WAIT, BUS_FINAL, BUS_HELD
  } busState_t;
endpackage : lbc_pkg

// ---- logic/local_bus_clock_reset_ctrl.sv ----
// Local bus front end: clock divider, reset stretcher, strobes, hold exchange, control block
module local_bus_clock_reset_ctrl (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic powerOnClearInputN,
  input wire logic busRequestIn,
  input wire logic syncReadyIn,
  input wire logic asyncReadyIn,
  input wire logic [15:0] muxedAddrDataIn,
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic cpuIo,
  input wire logic cpuLock,
  input wire logic cpuUpperByte,
  input wire logic [19:0] cpuAddr,
  input wire logic [15:0] cpuWdata,
  input wire logic [1:0] waitStates,
  input wire logic ignoreReady,
  output logic systemClockOutput,
  output logic resetOut,
  output logic ale,
  output logic busGrantOut,
  output logic [15:0] muxedAddrData,
  output logic muxedAddrDataOe,
  output logic [3:0] upperAddress,
  output logic upperAddressOe,
  output logic upperByteEnableN,
  output logic upperByteEnableOe,
  output logic [2:0] busCycleStatus,
  output logic busCycleStatusOe,
  output logic lockN,
  output logic lockOe,
  output logic readStrobeN,
  output logic readStrobeOe,
  output logic writeStrobeN,
  output logic writeStrobeOe,
  output logic transceiverEnableN,
  output logic transceiverEnableOe,
  output logic transceiverDirection,
  output logic transceiverDirectionOe,
  output logic cpuDone,
  output logic [15:0] cpuRdata,
  output logic followerMode,
  output logic coprocessorOpcodeTrap
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic resSync1_q, resSync2_q, reqSync1_q, reqSync2_q;
  logic srdySync1_q, srdySync2_q, ardySync1_q, ardySync2_q;

  // Two stages on every pin that arrives without phase relation
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resSync1_q <= 1'b0;
      resSync2_q <= 1'b0;
      reqSync1_q <= 1'b0;
      reqSync2_q <= 1'b0;
      srdySync1_q <= 1'b0;
      srdySync2_q <= 1'b0;
      ardySync1_q <= 1'b0;
      ardySync2_q <= 1'b0;
    end else begin
      resSync1_q <= powerOnClearInputN;
      resSync2_q <= resSync1_q;
      reqSync1_q <= busRequestIn;
      reqSync2_q <= reqSync1_q;
      srdySync1_q <= syncReadyIn;
      srdySync2_q <= srdySync1_q;
      ardySync1_q <= asyncReadyIn;
      ardySync2_q <= ardySync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Clock divider and reset stretcher
  // ----------------------------------------------------------------
  logic procClk_q, procClk_d, resetOut_d;
  logic [3:0] holdCnt_q, holdCnt_d;
  logic [1:0] resetAge_q, resetAge_d;
  logic resetDrive, phaseEn;

  // Divide by two; one edge of the oscillator moves the divider
  always_comb begin
    procClk_d = ~procClk_q;
    phaseEn = procClk_q;
    holdCnt_d = holdCnt_q;
    if (!resSync2_q) begin
      holdCnt_d = lbc_pkg::RESET_HOLD_MCLK;
    end else if (holdCnt_q != 4'h0) begin
      holdCnt_d = holdCnt_q - 4'h1;
    end
    resetOut_d = !resSync2_q || (holdCnt_q != 4'h0);
    resetAge_d = resetAge_q;
    if (!resetOut) begin
      resetAge_d = 2'h0;
    end else if (resetAge_q != lbc_pkg::RESET_DRIVE_MCLK) begin
      resetAge_d = resetAge_q + 2'h1;
    end
    resetDrive = resetOut && (resetAge_q != lbc_pkg::RESET_DRIVE_MCLK);
  end

  // Registers of the clock and reset group
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      procClk_q <= 1'b0;
      holdCnt_q <= lbc_pkg::RESET_HOLD_MCLK;
      resetOut <= 1'b1;
      resetAge_q <= 2'h0;
    end else begin
      procClk_q <= procClk_d;
      holdCnt_q <= holdCnt_d;
      resetOut <= resetOut_d;
      resetAge_q <= resetAge_d;
    end
  end

  assign systemClockOutput = procClk_q;

  // ----------------------------------------------------------------
  // Control block decode
  // ----------------------------------------------------------------
  logic [15:0] reloc_q, reloc_d;
  logic hitBlock, busReady;

  // Block sits on a 256-byte boundary in the space chosen by the map bit
  function automatic logic blockHit(input logic [19:0] a, input logic io,
                                    input logic [15:0] r);
    return (a[19:8] == r[lbc_pkg::RELOC_BASE_MSB:0]) &&
           (io != r[lbc_pkg::RELOC_MEM_BIT]);
  endfunction : blockHit

  assign hitBlock = blockHit(cpuAddr, cpuIo, reloc_q);
  assign busReady = ignoreReady || srdySync2_q || ardySync2_q;
  assign followerMode = reloc_q[lbc_pkg::RELOC_FOLLOW_BIT];
  assign coprocessorOpcodeTrap = reloc_q[lbc_pkg::RELOC_ESC_BIT];

  // ----------------------------------------------------------------
  // Bus sequencer and pin registers
  // ----------------------------------------------------------------
  lbc_pkg::busState_t state_q, state_d;
  logic [1:0] waitCnt_q, waitCnt_d;
  logic owned_q, owned_d, done_d;
  logic [15:0] rdata_d;
  logic [2:0] cycleStat;

  always_comb begin
    case ({cpuIo, cpuWrite})
      2'b00: cycleStat = lbc_pkg::STAT_MEM_RD;
      2'b01: cycleStat = lbc_pkg::STAT_MEM_WR;
      2'b10: cycleStat = lbc_pkg::STAT_IO_RD;
      default: cycleStat = lbc_pkg::STAT_IO_WR;
    endcase
  end

  // Next state, then the pin values that belong to it
  always_comb begin
    state_d = state_q;
    waitCnt_d = waitCnt_q;
    owned_d = owned_q;
    reloc_d = reloc_q;
    rdata_d = cpuRdata;
    done_d = 1'b0;
    if (resetOut) begin
      state_d = lbc_pkg::BUS_RESET;
      owned_d = 1'b0;
      reloc_d = lbc_pkg::RELOC_RESET;
    end else if (phaseEn) begin
      case (state_q)
        lbc_pkg::BUS_RESET: state_d = lbc_pkg::BUS_IDLE;
        lbc_pkg::BUS_IDLE: begin
          if (reqSync2_q) begin
            state_d = lbc_pkg::BUS_HELD;
          end else if (cpuReq) begin
            state_d = lbc_pkg::BUS_ADDR;
            owned_d = 1'b1;
          end
        end
        lbc_pkg::BUS_ADDR: state_d = lbc_pkg::BUS_STROBE;
        lbc_pkg::BUS_STROBE: begin
          state_d = lbc_pkg::BUS_WAIT;
          waitCnt_d = waitStates;
        end
        lbc_pkg::BUS_WAIT: begin
          if (hitBlock) begin
            state_d = lbc_pkg::BUS_FINAL;
            rdata_d = (cpuAddr[7:0] == lbc_pkg::RELOC_OFS) ? reloc_q : 16'h0000;
            if (cpuWrite && cpuAddr[7:0] == lbc_pkg::RELOC_OFS) begin
              reloc_d = cpuWdata & lbc_pkg::RELOC_WMASK;
            end
          end else if (waitCnt_q != 2'h0) begin
            waitCnt_d = waitCnt_q - 2'h1;
          end else if (busReady) begin
            state_d = lbc_pkg::BUS_FINAL;
            rdata_d = muxedAddrDataIn;
          end
        end
        lbc_pkg::BUS_FINAL: begin
          done_d = 1'b1;
          state_d = reqSync2_q ? lbc_pkg::BUS_HELD : lbc_pkg::BUS_IDLE;
        end
        lbc_pkg::BUS_HELD: begin
          owned_d = 1'b0;
          if (!reqSync2_q) begin
            state_d = lbc_pkg::BUS_IDLE;
          end
        end
        default: state_d = lbc_pkg::BUS_IDLE;
      endcase
    end
  end

  logic ale_d, grant_d, adOe_d, busOe_d, dtr_d, rd_d, wr_d, den_d, ctlOe_d, stOe_d;
  logic [15:0] ad_d;
  logic [2:0] stat_d;

  // Pin values for the state being entered
  always_comb begin
    ale_d = (state_d == lbc_pkg::BUS_ADDR);
    grant_d = (state_d == lbc_pkg::BUS_HELD);
    busOe_d = owned_d && (state_d != lbc_pkg::BUS_HELD);
    ctlOe_d = resetOut ? resetDrive : busOe_d;
    stOe_d = ctlOe_d;
    adOe_d = busOe_d && (state_d == lbc_pkg::BUS_ADDR ||
             (cpuWrite && state_d != lbc_pkg::BUS_IDLE));
    ad_d = (state_d == lbc_pkg::BUS_ADDR) ? cpuAddr[15:0] : cpuWdata;
    stat_d = (state_d == lbc_pkg::BUS_ADDR || state_d == lbc_pkg::BUS_STROBE) ?
             cycleStat : lbc_pkg::STAT_PASSIVE;
    dtr_d = (state_d == lbc_pkg::BUS_ADDR) ? cpuWrite : transceiverDirection;
    rd_d = !(!cpuWrite && (state_d == lbc_pkg::BUS_STROBE ||
             state_d == lbc_pkg::BUS_WAIT));
    wr_d = !(cpuWrite && (state_d == lbc_pkg::BUS_STROBE ||
             state_d == lbc_pkg::BUS_WAIT));
    den_d = !(state_d == lbc_pkg::BUS_STROBE || state_d == lbc_pkg::BUS_WAIT);
    if (resetOut) begin
      stat_d = lbc_pkg::STAT_PASSIVE;
      rd_d = 1'b1;
      wr_d = 1'b1;
      den_d = 1'b1;
    end
  end

  // Registers of the bus group; every pin leaves from a flip-flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= lbc_pkg::BUS_RESET;
      waitCnt_q <= 2'h0;
      owned_q <= 1'b0;
      reloc_q <= lbc_pkg::RELOC_RESET;
      cpuRdata <= 16'h0000;
      cpuDone <= 1'b0;
      ale <= 1'b0;
      busGrantOut <= 1'b0;
      muxedAddrData <= 16'h0000;
      muxedAddrDataOe <= 1'b0;
      upperAddress <= 4'h0;
      upperAddressOe <= 1'b0;
      upperByteEnableN <= 1'b1;
      upperByteEnableOe <= 1'b0;
      busCycleStatus <= lbc_pkg::STAT_PASSIVE;
      busCycleStatusOe <= 1'b0;
      lockN <= 1'b1;
      lockOe <= 1'b0;
      readStrobeN <= 1'b1;
      readStrobeOe <= 1'b0;
      writeStrobeN <= 1'b1;
      writeStrobeOe <= 1'b0;
      transceiverEnableN <= 1'b1;
      transceiverEnableOe <= 1'b0;
      transceiverDirection <= 1'b0;
      transceiverDirectionOe <= 1'b0;
    end else begin
      state_q <= state_d;
      waitCnt_q <= waitCnt_d;
      owned_q <= owned_d;
      reloc_q <= reloc_d;
      cpuRdata <= rdata_d;
      cpuDone <= done_d;
      ale <= ale_d;
      busGrantOut <= grant_d;
      muxedAddrData <= ad_d;
      muxedAddrDataOe <= adOe_d;
      upperAddress <= cpuAddr[19:16];
      upperAddressOe <= busOe_d && !resetOut;
      upperByteEnableN <= !cpuUpperByte;
      upperByteEnableOe <= busOe_d && !resetOut;
      busCycleStatus <= stat_d;
      busCycleStatusOe <= stOe_d;
      lockN <= resetOut ? 1'b1 : !cpuLock;
      lockOe <= stOe_d;
      readStrobeN <= rd_d;
      readStrobeOe <= ctlOe_d;
      writeStrobeN <= wr_d;
      writeStrobeOe <= ctlOe_d;
      transceiverEnableN <= den_d;
      transceiverEnableOe <= ctlOe_d;
      transceiverDirection <= dtr_d;
      transceiverDirectionOe <= busOe_d && !resetOut;
    end
  end
endmodule : local_bus_clock_reset_ctrl
